// >>> rtl/egress_queue_ratio_scheduler.v
/*
 Egress queue ratio scheduler: three 16-bit ratio registers on the
 host register port, and one four-queue arbiter each for ports 2, 3.
 Assumes the host port and transmit strobes share the core clock;
 the port 2 upper-queue register lives elsewhere and arrives as a bus.
 Writes land at the strobe edge; reads answer one cycle later and the
 read data holds until the next read.
 Reserved and unmapped word addresses read as zero and ignore writes.
 The low address bit is ignored, so both bytes of a word hit it.
*/
// Functional notes
// - Port 2 lowest queue mode is bit 15, reset 1; 0 means strict.
// - With mode 1 the 7-bit count caps packets sent in each period.
// - Port 2 lowest queue count is bits 14..8, read-write, reset 0x01.
// - Port 2 low queue mode is bit 7, reset 1; 0 means strict.
// - Low queue count of ports 2 and 3 is bits 6..0, reset 0x02.
// - Port 3 high queue mode is bit 15, reset 1; 0 means strict.
// - Port 3 high queue count is bits 14..8, read-write, reset 0x04.
// - Port 3 highest queue mode is bit 7, reset 1; 0 means strict.
// - Port 3 highest queue count is bits 6..0, read-write, reset 0x08.
// - Port 3 lowest queue mode is bit 15, reset 1; 0 means strict.
// - Port 3 lowest queue count is bits 14..8, reset 0x01.
// - Port 3 low queue mode is bit 7, reset 1; 0 means strict.
// - Offsets 0x0D4 and 0x0D5 read zero and ignore writes.
`timescale 1ns/1ps
`include "egress_queue_map.vh"

module egress_queue_ratio_scheduler #(
    parameter [15:0] PERIOD_CYCLES =
        (`PERIOD_NS * `CLOCK_MHZ) / 1000
) (
    // Clock, reset, enable
    input  wire        clock,
    input  wire        arst_n,
    input  wire        ce,
    // Host register port
    input  wire [10:0] reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [1:0]  reg_be,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    output reg         reg_rvalid,
    // Port 2 upper queue setting from its own register
    input  wire [15:0] p2_upper_cfg,
    // Port 2 transmit side
    input  wire [3:0]  p2_queue_pending,
    input  wire        p2_grant_take,
    input  wire        p2_packet_end,
    output wire        p2_grant_valid,
    output wire [1:0]  p2_grant_queue,
    output wire        p2_busy,
    // Port 3 transmit side
    input  wire [3:0]  p3_queue_pending,
    input  wire        p3_grant_take,
    input  wire        p3_packet_end,
    output wire        p3_grant_valid,
    output wire [1:0]  p3_grant_queue,
    output wire        p3_busy
);

    // ------------------------------------------------------------
    // Byte-lane write merge
    // ------------------------------------------------------------
    function [15:0] merge;
        input [15:0] old;
        input [15:0] wd;
        input [1:0]  be;
        begin
            merge = old;
            if (be[1])
                merge[`HI_BYTE_MSB:`HI_BYTE_LSB] =
                    wd[`HI_BYTE_MSB:`HI_BYTE_LSB];
            if (be[0])
                merge[`LO_BYTE_MSB:`LO_BYTE_LSB] =
                    wd[`LO_BYTE_MSB:`LO_BYTE_LSB];
        end
    endfunction

    // ------------------------------------------------------------
    // Word address compare, low address bit ignored
    // ------------------------------------------------------------
    function hit;
        input [10:0] a;
        input [10:0] base;
        begin
            hit = (a[10:1] == base[10:1]);
        end
    endfunction

    reg  [15:0] port2_lower_queues_ratio_q;
    reg  [15:0] port3_upper_queues_ratio_q;
    reg  [15:0] port3_lower_queues_ratio_q;
    reg  [15:0] port2_lower_queues_ratio_d;
    reg  [15:0] port3_upper_queues_ratio_d;
    reg  [15:0] port3_lower_queues_ratio_d;
    reg  [15:0] rdata_d;
    wire        sel_p2_lower;
    wire        sel_p3_upper;
    wire        sel_p3_lower;
    wire        wr_p2_lower;
    wire        wr_p3_upper;
    wire        wr_p3_lower;
    wire        rd_take;

    // ------------------------------------------------------------
    // Address decode and strobes
    // ------------------------------------------------------------
    assign sel_p2_lower = hit(reg_addr, `ADDR_P2_LOWER);
    assign sel_p3_upper = hit(reg_addr, `ADDR_P3_UPPER);
    assign sel_p3_lower = hit(reg_addr, `ADDR_P3_LOWER);
    // Reserved and unmapped offsets match no select, so writes drop
    assign wr_p2_lower  = reg_wr & sel_p2_lower;
    assign wr_p3_upper  = reg_wr & sel_p3_upper;
    assign wr_p3_lower  = reg_wr & sel_p3_lower;
    assign rd_take      = ce & reg_rd;

    // ------------------------------------------------------------
    // Register next values, byte lanes merged
    // ------------------------------------------------------------
    always @* begin
        port2_lower_queues_ratio_d = port2_lower_queues_ratio_q;
        port3_upper_queues_ratio_d = port3_upper_queues_ratio_q;
        port3_lower_queues_ratio_d = port3_lower_queues_ratio_q;
        if (wr_p2_lower)
            port2_lower_queues_ratio_d = merge(
                port2_lower_queues_ratio_q, reg_wdata, reg_be);
        if (wr_p3_upper)
            port3_upper_queues_ratio_d = merge(
                port3_upper_queues_ratio_q, reg_wdata, reg_be);
        if (wr_p3_lower)
            port3_lower_queues_ratio_d = merge(
                port3_lower_queues_ratio_q, reg_wdata, reg_be);
    end

    // ------------------------------------------------------------
    // Register flops
    // ------------------------------------------------------------
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // Modes 1, counts 0x01 and 0x02
            port2_lower_queues_ratio_q <= `RST_LOWER;
            // Modes 1, counts 0x04 and 0x08
            port3_upper_queues_ratio_q <= `RST_UPPER;
            // Modes 1, counts 0x01 and 0x02
            port3_lower_queues_ratio_q <= `RST_LOWER;
        end else if (ce) begin
            port2_lower_queues_ratio_q <= port2_lower_queues_ratio_d;
            port3_upper_queues_ratio_q <= port3_upper_queues_ratio_d;
            port3_lower_queues_ratio_q <= port3_lower_queues_ratio_d;
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always @* begin
        rdata_d = `DATA_ZERO;
        if (sel_p2_lower)
            rdata_d = port2_lower_queues_ratio_q;
        else if (sel_p3_upper)
            rdata_d = port3_upper_queues_ratio_q;
        else if (sel_p3_lower)
            rdata_d = port3_lower_queues_ratio_q;
    end

    // ------------------------------------------------------------
    // Read response
    // ------------------------------------------------------------
    // One-cycle read latency keeps read data from flops
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            reg_rvalid <= 1'b0;
        else if (ce)
            reg_rvalid <= reg_rd;
    end

    // Data holds between reads, for a slow host sampler
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            reg_rdata <= `DATA_ZERO;
        else if (rd_take)
            reg_rdata <= rdata_d;
    end

    // ------------------------------------------------------------
    // Port 2 arbiter
    // ------------------------------------------------------------
    queue_arbiter #(
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_port2_arbiter (
        .clock         (clock),
        .arst_n        (arst_n),
        .ce            (ce),
        .upper_cfg     (p2_upper_cfg),
        .lower_cfg     (port2_lower_queues_ratio_q),
        .queue_pending (p2_queue_pending),
        .grant_take    (p2_grant_take),
        .packet_end    (p2_packet_end),
        .grant_valid   (p2_grant_valid),
        .grant_queue   (p2_grant_queue),
        .busy          (p2_busy)
    );

    // ------------------------------------------------------------
    // Port 3 arbiter
    // ------------------------------------------------------------
    queue_arbiter #(
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_port3_arbiter (
        .clock         (clock),
        .arst_n        (arst_n),
        .ce            (ce),
        .upper_cfg     (port3_upper_queues_ratio_q),
        .lower_cfg     (port3_lower_queues_ratio_q),
        .queue_pending (p3_queue_pending),
        .grant_take    (p3_grant_take),
        .packet_end    (p3_packet_end),
        .grant_valid   (p3_grant_valid),
        .grant_queue   (p3_grant_queue),
        .busy          (p3_busy)
    );

endmodule // egress_queue_ratio_scheduler

// >>> shared/egress_queue_map.vh
/*
 Holds the register map, field positions, reset values and timing
 defaults of the egress queue ratio scheduler.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef EGRESS_QUEUE_MAP_VH
`define EGRESS_QUEUE_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_W                11
`define ADDR_P2_LOWER         11'h00CE
`define ADDR_P3_UPPER         11'h00D0
`define ADDR_P3_LOWER         11'h00D2
`define ADDR_RSVD_LO          11'h00D4
`define ADDR_RSVD_HI          11'h00D5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_UPPER             16'h8488
`define RST_LOWER             16'h8182
`define DATA_ZERO             16'h0000

// ----------------------------------------------------------------
// Field positions inside one 16-bit register
// ----------------------------------------------------------------
`define HI_MODE_BIT           15
`define HI_CNT_MSB            14
`define HI_CNT_LSB            8
`define LO_MODE_BIT           7
`define LO_CNT_MSB            6
`define LO_CNT_LSB            0
`define HI_BYTE_MSB           15
`define HI_BYTE_LSB           8
`define LO_BYTE_MSB           7
`define LO_BYTE_LSB           0

// ----------------------------------------------------------------
// Per-queue field of eight bits: mode on top, count below
// ----------------------------------------------------------------
`define FIELD_MODE            7
`define FIELD_CNT_MSB         6
`define FIELD_CNT_LSB         0
`define CNT_ZERO              7'h00
`define CNT_ONE               7'h01

// ----------------------------------------------------------------
// Queue indices and scheduling period
// ----------------------------------------------------------------
`define Q_LOWEST              2'h0
`define Q_LOW                 2'h1
`define Q_HIGH                2'h2
`define Q_HIGHEST             2'h3
`define NUM_QUEUES            4
`define PERIOD_NS             4096
`define CLOCK_MHZ             250
`define TIMER_W               16
`define TIMER_ZERO            16'h0000
`define TIMER_ONE             16'h0001

`endif

// >>> rtl/queue_arbiter.v
/*
 Four-queue egress arbiter for one port: strict or ratio service per
 queue, per-period credits, configuration swapped at packet boundary.
 Assumes the switch core clock, and grant/packet strobes on that clock.
*/
`timescale 1ns/1ps
`include "egress_queue_map.vh"

module queue_arbiter #(
    parameter [15:0] PERIOD_CYCLES = 16'h0400
) (
    // Clock and reset
    input  wire        clock,
    input  wire        arst_n,
    input  wire        ce,
    // Programmed configuration
    input  wire [15:0] upper_cfg,
    input  wire [15:0] lower_cfg,
    // Transmit side
    input  wire [3:0]  queue_pending,
    input  wire        grant_take,
    input  wire        packet_end,
    output reg         grant_valid,
    output reg  [1:0]  grant_queue,
    output wire        busy
);

    // ------------------------------------------------------------
    // Field selection
    // ------------------------------------------------------------
    function [7:0] queue_field;
        input [15:0] up;
        input [15:0] lo;
        input [1:0]  q;
        begin
            case (q)
                `Q_HIGHEST: queue_field = up[`LO_BYTE_MSB:`LO_BYTE_LSB];
                `Q_HIGH:    queue_field = up[`HI_BYTE_MSB:`HI_BYTE_LSB];
                `Q_LOW:     queue_field = lo[`LO_BYTE_MSB:`LO_BYTE_LSB];
                default:    queue_field = lo[`HI_BYTE_MSB:`HI_BYTE_LSB];
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Count field of one queue, mode bit cut off on purpose
    // ------------------------------------------------------------
    function [6:0] queue_count;
        input [15:0] up;
        input [15:0] lo;
        input [1:0]  q;
        reg   [7:0]  f;
        begin
            f           = queue_field(up, lo, q);
            queue_count = f[`FIELD_CNT_MSB:`FIELD_CNT_LSB];
        end
    endfunction

    reg  [15:0] act_upper_q;
    reg  [15:0] act_lower_q;
    reg         busy_q;
    reg  [15:0] timer_q;
    reg  [6:0]  credit_q [0:3];
    reg  [3:0]  eligible;
    reg  [7:0]  fld;
    wire        period_tick;
    integer     i;
    integer     j;

    assign busy        = busy_q;
    assign period_tick = (timer_q == PERIOD_CYCLES - `TIMER_ONE);

    // ------------------------------------------------------------
    // Eligibility and priority pick, highest index wins
    // ------------------------------------------------------------
    always @* begin
        fld         = 8'h00;
        eligible    = 4'h0;
        grant_valid = 1'b0;
        grant_queue = `Q_LOWEST;
        for (i = 0; i < `NUM_QUEUES; i = i + 1) begin
            fld = queue_field(act_upper_q, act_lower_q, i[1:0]);
            // Strict queues need only traffic; ratio queues need credit
            eligible[i] = queue_pending[i] &
                          (~fld[`FIELD_MODE] |
                           (credit_q[i] != `CNT_ZERO));
            if (eligible[i]) begin
                grant_valid = ~busy_q;
                grant_queue = i[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Active configuration, busy flag and period timer
    // ------------------------------------------------------------
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            act_upper_q <= `RST_UPPER;
            act_lower_q <= `RST_LOWER;
            busy_q      <= 1'b0;
            timer_q     <= `TIMER_ZERO;
        end else if (ce) begin
            // Never swap mid-packet, so a frame in flight is unharmed
            if (!busy_q && !grant_take) begin
                act_upper_q <= upper_cfg;
                act_lower_q <= lower_cfg;
            end
            if (grant_take)
                busy_q <= 1'b1;
            else if (packet_end)
                busy_q <= 1'b0;
            timer_q <= period_tick ? `TIMER_ZERO : timer_q + `TIMER_ONE;
        end
    end

    // ------------------------------------------------------------
    // Credits: reload each period, spend one per granted packet, strict or ratio, down to zero
    // ------------------------------------------------------------
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            credit_q[0] <= queue_count(`RST_UPPER, `RST_LOWER, `Q_LOWEST);
            credit_q[1] <= queue_count(`RST_UPPER, `RST_LOWER, `Q_LOW);
            credit_q[2] <= queue_count(`RST_UPPER, `RST_LOWER, `Q_HIGH);
            credit_q[3] <= queue_count(`RST_UPPER, `RST_LOWER, `Q_HIGHEST);
        end else if (ce) begin
            for (j = 0; j < `NUM_QUEUES; j = j + 1) begin
                if (period_tick)
                    credit_q[j] <= queue_count(act_upper_q, act_lower_q,
                        j[1:0]);
                else if (grant_take && grant_valid &&
                         grant_queue == j[1:0] &&
                         credit_q[j] != `CNT_ZERO)
                    credit_q[j] <= credit_q[j] - `CNT_ONE;
            end
        end
    end

endmodule // queue_arbiter

// >>> test/egress_queue_ratio_scheduler_sva.sv
/* Port checker for the egress queue ratio scheduler.
 Assumes one core clock and the low-active asynchronous reset. */
`timescale 1ns/1ps
module egress_queue_ratio_scheduler_sva (
    // Clock and reset
    input wire        clock,
    input wire        arst_n,
    input wire        ce,
    // Host port
    input wire [10:0] reg_addr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire        reg_rvalid,
    // Transmit sides
    input wire [3:0]  p2_queue_pending,
    input wire        p2_grant_valid,
    input wire        p2_busy,
    input wire [3:0]  p3_queue_pending,
    input wire        p3_grant_take,
    input wire        p3_packet_end,
    input wire        p3_grant_valid,
    input wire [1:0]  p3_grant_queue,
    input wire        p3_busy
);
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
default clocking cb @(posedge clock); endclocking
default disable iff (!arst_n);
a_rvalid_after_rd: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read gave no valid");
a_rvalid_has_cause: assert property (reg_rvalid && $past(ce) |->
    $past(reg_rd)) else $error("valid without read");
a_reserved_reads_zero: assert property (ce && reg_rd &&
    reg_addr[10:1] == 10'h06A |=> reg_rdata == 16'h0000)
    else $error("reserved read not zero");
a_rdata_held: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
a_take_sets_busy: assert property (ce && p3_grant_take &&
    p3_grant_valid |=> p3_busy)
    else $error("take gave no busy");
a_busy_blocks_grant: assert property (p3_busy |-> !p3_grant_valid)
    else $error("grant during packet");
a_busy_until_end: assert property (p3_busy && !p3_packet_end
    |=> p3_busy) else $error("busy dropped early");
a_end_clears_busy: assert property (ce && p3_busy && p3_packet_end
    && !p3_grant_take |=> !p3_busy) else $error("busy stuck");
a_grant_needs_pending: assert property (p3_grant_valid
    |-> p3_queue_pending[p3_grant_queue])
    else $error("grant to empty queue");
a_idle_no_grant: assert property (p2_queue_pending == 4'h0
    |-> !p2_grant_valid) else $error("grant with nothing pending");
c_reserved_read: cover property (reg_rd && reg_addr == 11'h0D4);
c_p3_packet: cover property (p3_busy ##1 p3_packet_end);
c_p2_grant: cover property (p2_grant_valid && p2_busy == 1'b0);
endmodule // egress_queue_ratio_scheduler_sva

bind egress_queue_ratio_scheduler egress_queue_ratio_scheduler_sva
    i_egress_queue_ratio_scheduler_sva (.clock, .arst_n, .ce,
    .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .p2_queue_pending,
    .p2_grant_valid, .p2_busy, .p3_queue_pending, .p3_grant_take,
    .p3_packet_end, .p3_grant_valid, .p3_grant_queue, .p3_busy);

// >>> test/test_egress_queue_ratio_scheduler.sv
/* Self-checking bench for the egress queue ratio scheduler.
 Assumes a 256-cycle period override; ce drops only briefly. */
`timescale 1ns/1ps
module test_egress_queue_ratio_scheduler;
// ----------------------------------------------------------------
// Stimulus and observation
// ----------------------------------------------------------------
reg         clock = 0, arst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0;
reg  [10:0] reg_addr = 0;
reg  [1:0]  reg_be = 0, take = 0, pkt_end = 0, qq;
reg  [15:0] reg_wdata = 0, rnd, rq[$], gq[$];
reg  [3:0]  p2_pend = 0, p3_pend = 0;
reg         pp;
wire [15:0] reg_rdata;
wire        reg_rvalid;
wire [1:0]  gv, busy, gq2, gq3;
integer     err_total = 0, n_checks = 0, seed = 75290, r, i, k;

always #2 clock = ~clock;

egress_queue_ratio_scheduler #(.PERIOD_CYCLES(16'h0100))
    i_egress_queue_ratio_scheduler (.clock(clock), .arst_n(arst_n),
    .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .p2_upper_cfg(16'h8488),
    .p2_queue_pending(p2_pend), .p2_grant_take(take[0]),
    .p2_packet_end(pkt_end[0]), .p2_grant_valid(gv[0]),
    .p2_grant_queue(gq2), .p2_busy(busy[0]),
    .p3_queue_pending(p3_pend), .p3_grant_take(take[1]),
    .p3_packet_end(pkt_end[1]), .p3_grant_valid(gv[1]),
    .p3_grant_queue(gq3), .p3_busy(busy[1]));

task chk(input [15:0] seen, input [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
endtask

task test_done;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask

task wr(input [10:0] a, input [1:0] be, input [15:0] d);
    @(negedge clock);
    reg_wr = 1; reg_addr = a; reg_be = be; reg_wdata = d;
    @(negedge clock);
    reg_wr = 0;
endtask

task rd(input [10:0] a, input [15:0] e);
    @(negedge clock);
    reg_rd = 1; reg_addr = a; rq.push_back(e);
    @(negedge clock);
    reg_rd = 0;
endtask

// Waits out a spent period too, so bound exceeds one period
task pkt(input p, input [1:0] q);
    integer n;
    n = 0;
    @(negedge clock);
    while (gv[p] !== 1'b1 && n < 600) begin
        @(negedge clock);
        n = n + 1;
    end
    if (n == 600) begin
        err_total = err_total + 1;
        test_done;
    end
    gq.push_back({14'h0000, q});
    take[p] = 1;
    @(negedge clock);
    take[p] = 0;
    chk({15'h0000, busy[p]}, 16'h0001);
    chk({15'h0000, gv[p]}, 16'h0000);
    @(negedge clock);
    pkt_end[p] = 1;
    @(negedge clock);
    pkt_end[p] = 0;
    chk({15'h0000, busy[p]}, 16'h0000);
endtask

// ----------------------------------------------------------------
// Monitors: read data mid-cycle, grants before edge updates land
// ----------------------------------------------------------------
always @(negedge clock)
    if (reg_rvalid === 1'b1)
        chk(reg_rdata, rq.size() ? rq.pop_front() : 16'hDEAD);
always @(posedge clock) begin
    if (take[1] && gq.size()) chk({14'h0000, gq3}, gq.pop_front());
    if (take[0] && gq.size()) chk({14'h0000, gq2}, gq.pop_front());
end

initial begin
    repeat (10) @(negedge clock);
    arst_n = 1;
    rd(11'h00CE, 16'h8182);
    rd(11'h00D0, 16'h8488);
    rd(11'h00D2, 16'h8182);
    rd(11'h00D4, 16'h0000);
    rd(11'h00D6, 16'h0000);
    // Enable low freezes the read port
    @(negedge clock);
    ce = 0; reg_rd = 1; reg_addr = 11'h00D0;
    @(negedge clock);
    chk({15'h0000, reg_rvalid}, 16'h0000);
    chk(reg_rdata, 16'h0000);
    ce = 1; reg_rd = 0;
    // Ratio credits at reset counts, synced on a reload
    p3_pend = 4'b0001;
    pkt(1, 2'h0);
    @(negedge clock);
    chk({15'h0000, gv[1]}, 16'h0000);
    pkt(1, 2'h0);
    p3_pend = 4'b1110;
    for (i = 0; i < 14; i = i + 1)
        pkt(1, i < 8 ? 2'h3 : (i < 12 ? 2'h2 : 2'h1));
    @(negedge clock);
    chk({15'h0000, gv[1]}, 16'h0000);
    r = $random(seed);
    rnd = r[15:0];
    wr(11'h00D4, 2'b11, rnd);
    rd(11'h00D4, 16'h0000);
    wr(11'h00D0, 2'b11, rnd);
    rd(11'h00D1, rnd);
    wr(11'h00D2, 2'b01, ~rnd);
    rd(11'h00D2, {8'h81, ~rnd[7:0]});
    // Strict service beyond any credit, each port 3 queue in turn, then port 2 low and lowest
    wr(11'h00D0, 2'b11, 16'h0000);
    wr(11'h00D2, 2'b11, 16'h0000);
    wr(11'h00CE, 2'b11, 16'h0000);
    for (k = 0; k < 6; k = k + 1) begin
        pp = (k < 4);
        qq = pp ? 3 - k : 5 - k;
        if (pp)
            p3_pend = (4'b0001 << qq) | 4'b0001;
        else
            p2_pend = (4'b0001 << qq) | 4'b0001;
        repeat (10) pkt(pp, qq);
    end
    repeat (2) @(negedge clock);
    chk(16'(rq.size() + gq.size()), 16'h0000);
    test_done;
end
endmodule // test_egress_queue_ratio_scheduler
